/* File: cexs_addr_chk.v */
// address error decode for one core access
`timescale 1ns/1ps
`include "cexs_defines.vh"
module cexs_addr_chk (
  input wire [15:0] addr_i,
  input wire [1:0] kind_i,
  input wire single_chip_i,
  input wire ram_en_i,
  output wire err_o
);
  wire is_fetch;
  wire in_hole;
  wire in_ram;
  wire in_regf;
  wire odd_word;

  // range decode; the hole also catches the prefetch past the last rom bytes
  assign is_fetch = (kind_i == `CEXS_ACC_FETCH);
  assign in_hole = (addr_i >= `CEXS_HOLE_LO) && (addr_i <= `CEXS_HOLE_HI);
  assign in_ram = (addr_i >= `CEXS_RAM_LO) && (addr_i <= `CEXS_RAM_HI);
  assign in_regf = (addr_i >= `CEXS_REGF_LO);
  assign odd_word = (kind_i == `CEXS_ACC_WORD) && addr_i[0];

  // fault sources ored together
  assign err_o = (single_chip_i & in_hole) |
                 (single_chip_i & in_ram & ~ram_en_i) |
                 odd_word |
                 (is_fetch & in_regf);
endmodule // cexs_addr_chk

/* File: cexs_defines.vh */
// constants and field layout of the cpu exception sequencer
`ifndef CEXS_DEFINES_VH
`define CEXS_DEFINES_VH

// address map of the 64k page
`define CEXS_HOLE_LO 16'h8000
`define CEXS_HOLE_HI 16'hF67F
`define CEXS_RAM_LO 16'hF680
`define CEXS_RAM_HI 16'hFE7F
`define CEXS_REGF_LO 16'hFE80

// access kinds from the core
`define CEXS_ACC_FETCH 2'h0
`define CEXS_ACC_BYTE 2'h1
`define CEXS_ACC_WORD 2'h2

// exception kinds on exc_kind_o
`define CEXS_K_NONE 4'h0
`define CEXS_K_ADDR 4'h1
`define CEXS_K_INV 4'h2
`define CEXS_K_ZDIV 4'h3
`define CEXS_K_VTRAP 4'h4
`define CEXS_K_OVTRAP 4'h5
`define CEXS_K_TRACE 4'h6
`define CEXS_K_NMI 4'h7
`define CEXS_K_IRQ 4'h8

// register byte offsets
`define CEXS_R_CTRL 8'h00
`define CEXS_R_RAMCTL 8'h04
`define CEXS_R_PRIO0 8'h08
`define CEXS_R_PRIO1 8'h0C
`define CEXS_R_XFEREN 8'h10
`define CEXS_R_STAT 8'h14

// field positions and reset values
`define CEXS_B_SCHIP 0
`define CEXS_B_NMIRISE 1
`define CEXS_B_RAMEN 0
`define CEXS_CTRL_RST 32'h0000_0001
`define CEXS_RAMCTL_RST 32'h0000_0001
`define CEXS_MASK_RST 3'h7
`define CEXS_NMI_MASK 3'h7
`define CEXS_RESP_OK 2'h0
`define CEXS_RESP_ERR 2'h2

`endif

/* File: cexs_seq.v */
// cpu exception sequencer: fault capture, interrupt arbitration, dispatch
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cexs_defines.vh"
module cexs_seq #(
  parameter NINT = 23,
  parameter NSRC = 29
) (
  input wire clk_i,
  input wire resetn_i,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // request pins and on-chip requests
  input wire nmi_i,
  input wire [5:0] ext_req_n_i,
  input wire [NINT-1:0] int_req_i,
  // core side
  input wire acc_valid_i,
  input wire [15:0] acc_addr_i,
  input wire [1:0] acc_kind_i,
  input wire insn_done_i,
  input wire insn_ctrl_op_i,
  input wire insn_invalid_i,
  input wire insn_vtrap_i,
  input wire [3:0] insn_vtrap_num_i,
  input wire insn_ovtrap_i,
  input wire ovf_flag_i,
  input wire insn_divu_i,
  input wire divisor_zero_i,
  input wire boundary_i,
  input wire exc_done_i,
  input wire sr_load_i,
  input wire sr_trace_i,
  input wire [2:0] sr_mask_i,
  output reg exc_start_o,
  output reg [3:0] exc_kind_o,
  output reg [4:0] exc_vec_o,
  output reg push_trace_o,
  output reg trace_bit_o,
  output reg [2:0] mask_level_o,
  output reg cpu_halt_o,
  // block transfer unit
  output reg xfer_start_o,
  output reg [4:0] xfer_src_o,
  input wire xfer_done_i
);
  ////////////////////////////////////////////////////////////////////
  // registers reached over the bus
  reg [31:0] ctrl_ff;
  reg [31:0] ramctl_ff;
  reg [31:0] prio0_ff;
  reg [31:0] prio1_ff;
  reg [31:0] xferen_ff;
  reg aw_ok_ff;
  reg w_ok_ff;
  reg [7:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  wire do_wr;
  wire ar_hs;
  reg [31:0] nxt_rdata;
  reg nxt_rerr;
  wire [31:0] stat_word;

  // merge write data under byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = din[b*8 +: 8];
        end
      end
    end
  endfunction

  assign do_wr = aw_ok_ff & w_ok_ff & ~s_axi_bvalid_o;
  assign ar_hs = s_axi_arvalid_i & s_axi_arready_o;

  // write channels taken in either order, response once both are in
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `CEXS_RESP_OK;
      ctrl_ff <= `CEXS_CTRL_RST;
      ramctl_ff <= `CEXS_RAMCTL_RST;
      prio0_ff <= 32'h0000_0000;
      prio1_ff <= 32'h0000_0000;
      xferen_ff <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_ok_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_ok_ff <= 1'b1;
        w_data_ff <= s_axi_wdata_i;
        w_strb_ff <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= `CEXS_RESP_OK;
        case (aw_addr_ff)
          `CEXS_R_CTRL: ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff);
          `CEXS_R_RAMCTL: ramctl_ff <= merge(ramctl_ff, w_data_ff, w_strb_ff);
          `CEXS_R_PRIO0: prio0_ff <= merge(prio0_ff, w_data_ff, w_strb_ff);
          `CEXS_R_PRIO1: prio1_ff <= merge(prio1_ff, w_data_ff, w_strb_ff);
          `CEXS_R_XFEREN: xferen_ff <= merge(xferen_ff, w_data_ff, w_strb_ff);
          `CEXS_R_STAT: s_axi_bresp_o <= `CEXS_RESP_OK;
          default: s_axi_bresp_o <= `CEXS_RESP_ERR;
        endcase
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // read decode
  always @* begin
    nxt_rerr = 1'b0;
    case (s_axi_araddr_i)
      `CEXS_R_CTRL: nxt_rdata = ctrl_ff;
      `CEXS_R_RAMCTL: nxt_rdata = ramctl_ff;
      `CEXS_R_PRIO0: nxt_rdata = prio0_ff;
      `CEXS_R_PRIO1: nxt_rdata = prio1_ff;
      `CEXS_R_XFEREN: nxt_rdata = xferen_ff;
      `CEXS_R_STAT: nxt_rdata = stat_word;
      default: begin
        nxt_rdata = 32'h0000_0000;
        nxt_rerr = 1'b1;
      end
    endcase
  end

  // one read at a time; arready drops while the answer waits
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `CEXS_RESP_OK;
    end else if (ar_hs) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= nxt_rdata;
      s_axi_rresp_o <= nxt_rerr ? `CEXS_RESP_ERR : `CEXS_RESP_OK;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  reg [6:0] pin_s1_ff;
  reg [6:0] pin_s2_ff;
  reg [6:0] pin_s3_ff;
  reg [6:0] pin_ff;
  reg nmi_prev_ff;
  wire nmi_edge;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_ff <= 7'h7E;
      pin_s2_ff <= 7'h7E;
      pin_s3_ff <= 7'h7E;
      pin_ff <= 7'h7E;
      nmi_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff <= {ext_req_n_i, nmi_i};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff ^ pin_s3_ff));
      nmi_prev_ff <= pin_ff[0];
    end
  end

  // nonmaskable input is edge sensed, edge chosen by software
  assign nmi_edge = ctrl_ff[`CEXS_B_NMIRISE] ? (pin_ff[0] & ~nmi_prev_ff) : (~pin_ff[0] & nmi_prev_ff);

  ////////////////////////////////////////////////////////////////////
  // per-source level lookup and arbitration
  wire [NSRC-1:0] req;
  wire [NSRC*3-1:0] lvl_flat;
  wire [63:0] prio_all;
  reg [2:0] mask_ff;
  reg [4:0] win_idx;
  reg [2:0] win_lvl;
  reg win_ok;
  integer k;

  assign req = {int_req_i, ~pin_ff[6:1]};
  assign prio_all = {prio1_ff, prio0_ff};

  // group map: 0,1 alone, 2/3 and 4/5 paired, internals three to a module
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_lvl
      localparam GRP = (gi < 2) ? gi : (gi < 4) ? 2 : (gi < 6) ? 3 : 4 + (gi - 6) / 3;
      assign lvl_flat[gi*3 +: 3] = prio_all[GRP*4 +: 3];
    end
  endgenerate

  // highest level above the mask wins, lowest index breaks ties
  always @* begin
    win_idx = 5'h00;
    win_lvl = 3'h0;
    win_ok = 1'b0;
    for (k = 0; k < NSRC; k = k + 1) begin
      if (req[k] && (lvl_flat[k*3 +: 3] > mask_ff) && (!win_ok || lvl_flat[k*3 +: 3] > win_lvl)) begin
        win_ok = 1'b1;
        win_lvl = lvl_flat[k*3 +: 3];
        win_idx = k[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fault capture and pending exceptions
  wire acc_err;
  reg trace_ff;
  reg ae_pend_ff;
  reg sw_pend_ff;
  reg [3:0] sw_kind_ff;
  reg [3:0] sw_num_ff;
  reg trace_pend_ff;
  reg nmi_pend_ff;
  reg block_ff;
  reg busy_ff;
  reg xfer_ff;
  wire svc_ok;
  wire sw_evt;
  reg [3:0] sw_kind_evt;

  cexs_addr_chk u_addr_chk (
    .addr_i(acc_addr_i),
    .kind_i(acc_kind_i),
    .single_chip_i(ctrl_ff[`CEXS_B_SCHIP]),
    .ram_en_i(ramctl_ff[`CEXS_B_RAMEN]),
    .err_o(acc_err)
  );

  // instruction-raised exceptions; one per instruction at most
  always @* begin
    if (insn_invalid_i) begin
      sw_kind_evt = `CEXS_K_INV;
    end else if (insn_divu_i && divisor_zero_i) begin
      sw_kind_evt = `CEXS_K_ZDIV;
    end else if (insn_vtrap_i) begin
      sw_kind_evt = `CEXS_K_VTRAP;
    end else if (insn_ovtrap_i && ovf_flag_i) begin
      sw_kind_evt = `CEXS_K_OVTRAP;
    end else begin
      sw_kind_evt = `CEXS_K_NONE;
    end
  end
  assign sw_evt = insn_done_i && (sw_kind_evt != `CEXS_K_NONE);

  // only at a boundary, never while deferred, busy or halted for a transfer
  assign svc_ok = boundary_i & ~block_ff & ~busy_ff & ~xfer_ff & ~exc_start_o & ~xfer_start_o;

  ////////////////////////////////////////////////////////////////////
  // dispatch: one exception per boundary, fixed precedence
  reg [3:0] nxt_kind;
  reg [4:0] nxt_vec;
  reg nxt_go;
  reg nxt_xfer;

  always @* begin
    nxt_kind = `CEXS_K_NONE;
    nxt_vec = 5'h00;
    nxt_go = 1'b0;
    nxt_xfer = 1'b0;
    if (svc_ok) begin
      if (ae_pend_ff) begin
        nxt_kind = `CEXS_K_ADDR;
        nxt_go = 1'b1;
      end else if (sw_pend_ff) begin
        nxt_kind = sw_kind_ff;
        nxt_vec = {1'b0, sw_num_ff};
        nxt_go = 1'b1;
      end else if (trace_pend_ff) begin
        nxt_kind = `CEXS_K_TRACE;
        nxt_go = 1'b1;
      end else if (nmi_pend_ff) begin
        nxt_kind = `CEXS_K_NMI;
        nxt_go = 1'b1;
      end else if (win_ok) begin
        nxt_vec = win_idx;
        if (xferen_ff[win_idx]) begin
          nxt_xfer = 1'b1;
        end else begin
          nxt_kind = `CEXS_K_IRQ;
          nxt_go = 1'b1;
        end
      end
    end
  end

  // pending flags: a new event wins over the clear in the same cycle
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ae_pend_ff <= 1'b0;
      sw_pend_ff <= 1'b0;
      sw_kind_ff <= `CEXS_K_NONE;
      sw_num_ff <= 4'h0;
      trace_pend_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
    end else begin
      if (acc_valid_i && acc_err) begin
        ae_pend_ff <= 1'b1;
      end else if (nxt_kind == `CEXS_K_ADDR) begin
        ae_pend_ff <= 1'b0;
      end
      if (sw_evt) begin
        sw_pend_ff <= 1'b1;
        sw_kind_ff <= sw_kind_evt;
        sw_num_ff <= insn_vtrap_i ? insn_vtrap_num_i : 4'h0;
      end else if (nxt_go && (nxt_kind == sw_kind_ff) && sw_pend_ff) begin
        sw_pend_ff <= 1'b0;
      end
      if (insn_done_i && trace_ff) begin
        trace_pend_ff <= 1'b1;
      end else if (nxt_kind == `CEXS_K_TRACE || nxt_kind == `CEXS_K_ADDR) begin
        trace_pend_ff <= 1'b0;
      end
      if (nmi_edge) begin
        nmi_pend_ff <= 1'b1;
      end else if (nxt_kind == `CEXS_K_NMI) begin
        nmi_pend_ff <= 1'b0;
      end
    end
  end

  // deferral: reset, control ops and transfer ends block until an ordinary instruction runs
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      block_ff <= 1'b1;
    end else if (xfer_ff && xfer_done_i) begin
      block_ff <= 1'b1;
    end else if (insn_done_i) begin
      block_ff <= insn_ctrl_op_i;
    end
  end

  // status word: every sequence clears trace; only interrupts move the mask
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trace_ff <= 1'b0;
      mask_ff <= `CEXS_MASK_RST;
    end else if (nxt_go) begin
      trace_ff <= 1'b0;
      if (nxt_kind == `CEXS_K_IRQ) begin
        mask_ff <= win_lvl;
      end else if (nxt_kind == `CEXS_K_NMI) begin
        mask_ff <= `CEXS_NMI_MASK;
      end
    end else if (sr_load_i) begin
      trace_ff <= sr_trace_i;
      mask_ff <= sr_mask_i;
    end
  end

  // sequence and transfer tracking
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_ff <= 1'b0;
      xfer_ff <= 1'b0;
    end else begin
      if (nxt_go) begin
        busy_ff <= 1'b1;
      end else if (exc_done_i) begin
        busy_ff <= 1'b0;
      end
      if (nxt_xfer) begin
        xfer_ff <= 1'b1;
      end else if (xfer_done_i) begin
        xfer_ff <= 1'b0;
      end
    end
  end

  // core and transfer-unit outputs, all registered
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      exc_start_o <= 1'b0;
      exc_kind_o <= `CEXS_K_NONE;
      exc_vec_o <= 5'h00;
      push_trace_o <= 1'b0;
      trace_bit_o <= 1'b0;
      mask_level_o <= `CEXS_MASK_RST;
      cpu_halt_o <= 1'b0;
      xfer_start_o <= 1'b0;
      xfer_src_o <= 5'h00;
    end else begin
      exc_start_o <= nxt_go;
      if (nxt_go) begin
        exc_kind_o <= nxt_kind;
        exc_vec_o <= nxt_vec;
        // a trace entry always pushes the bit set, even right after a trap cleared it
        push_trace_o <= trace_ff | (nxt_kind == `CEXS_K_TRACE);
      end
      trace_bit_o <= nxt_go ? 1'b0 : (sr_load_i ? sr_trace_i : trace_ff);
      mask_level_o <= nxt_go ? ((nxt_kind == `CEXS_K_IRQ) ? win_lvl :
                      (nxt_kind == `CEXS_K_NMI) ? `CEXS_NMI_MASK : mask_ff) :
                      (sr_load_i ? sr_mask_i : mask_ff);
      cpu_halt_o <= nxt_xfer | (xfer_ff & ~xfer_done_i);
      xfer_start_o <= nxt_xfer;
      if (nxt_xfer) begin
        xfer_src_o <= nxt_vec;
      end
    end
  end

  // status seen by software
  assign stat_word = {17'h0_0000, xfer_ff, busy_ff, block_ff, nmi_pend_ff, trace_pend_ff,
                      sw_pend_ff, ae_pend_ff, 4'h0, mask_ff, trace_ff};
endmodule // cexs_seq

/* File: cexs_seq_checker.sv */
// port-level assertions for the exception sequencer
`timescale 1ns/1ps
`include "cexs_defines.vh"
module cexs_seq_checker (
  input wire clk_i,
  input wire resetn_i,
  input wire insn_done_i,
  input wire insn_ctrl_op_i,
  input wire boundary_i,
  input wire xfer_done_i,
  input wire exc_start_o,
  input wire [3:0] exc_kind_o,
  input wire trace_bit_o,
  input wire [2:0] mask_level_o,
  input wire cpu_halt_o,
  input wire xfer_start_o
);
  reg hold_ff;
  wire nxt_hold;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // hold window: reset, control op or transfer end, until a plain instruction
  assign nxt_hold = (cpu_halt_o & xfer_done_i) | (insn_done_i & insn_ctrl_op_i) | (hold_ff & ~insn_done_i);
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_ff <= 1'b1;
    end else begin
      hold_ff <= nxt_hold;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_xfer_end;
    cpu_halt_o && xfer_done_i;
  endsequence
  sequence s_exc_flat;
    exc_start_o && exc_kind_o >= `CEXS_K_ADDR && exc_kind_o <= `CEXS_K_TRACE;
  endsequence
  a_start_single: assert property (exc_start_o |=> !exc_start_o)
    else $error("exception start longer than one cycle");
  a_start_boundary: assert property (exc_start_o |-> $past(boundary_i))
    else $error("exception start without boundary");
  a_defer_hold: assert property (hold_ff && $past(hold_ff) |-> !exc_start_o)
    else $error("exception started inside deferral");
  a_halt_begin: assert property (xfer_start_o |-> ##[0:1] cpu_halt_o)
    else $error("transfer start without halt");
  a_halt_end: assert property (s_xfer_end |=> !cpu_halt_o)
    else $error("halt outlives transfer");
  a_halt_quiet: assert property (cpu_halt_o |-> !exc_start_o)
    else $error("exception during transfer");
  a_route_once: assert property (xfer_start_o |-> !exc_start_o ##1 !xfer_start_o)
    else $error("request routed twice");
  a_trace_clear: assert property (exc_start_o |-> ##[0:3] !trace_bit_o)
    else $error("trace bit not cleared");
  a_mask_kept: assert property (s_exc_flat |=> $stable(mask_level_o) [*2])
    else $error("mask changed by exception");
  a_nmi_mask: assert property (exc_start_o && exc_kind_o == `CEXS_K_NMI |-> ##[0:3] mask_level_o == 3'h7)
    else $error("nonmaskable entry did not raise mask");
endmodule // cexs_seq_checker

/* File: cexs_xfer_model.sv */
// block transfer unit model: one done pulse per start, short or long run
`timescale 1ns/1ps
module cexs_xfer_model (
  input wire clk_i,
  input wire resetn_i,
  input wire xfer_start_i,
  input wire slow_i,
  output reg xfer_done_o
);
  reg busy_ff;
  reg [3:0] cnt_ff;
  // long run keeps the cpu halted long enough for pins to change meanwhile
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      xfer_done_o <= 1'b0;
    end else begin
      xfer_done_o <= 1'b0;
      if (xfer_start_i) begin
        busy_ff <= 1'b1;
        cnt_ff <= slow_i ? 4'h9 : 4'h0;
      end else if (busy_ff && cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
        xfer_done_o <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule // cexs_xfer_model

/* File: cpu_exception_sequencer_tb.sv */
// self-checking bench for the exception sequencer
`timescale 1ns/1ps
`include "cexs_defines.vh"
module cpu_exception_sequencer_tb;
  reg clk_i, resetn_i, awv, wv, brdy, arv, rrdy, nmi, accv, idone, bnd, edone, srl_p, srt, slow;
  reg ctl, inv, vt, ovt, ovf, dvu, dz;
  reg [7:0] awa, ara;
  reg [31:0] wd, seed, rd;
  reg [5:0] ereq_n;
  reg [22:0] ireq;
  reg [15:0] aad, t;
  reg [1:0] akd, r;
  reg [3:0] vtn;
  reg [2:0] srm;
  reg [19:0] e;
  wire awr, wr, bv, arr, rv, est, ptr, trb, halt, xst, xdn;
  wire [1:0] brs, rrs;
  wire [31:0] rdt;
  wire [3:0] ekd;
  wire [4:0] evc, xsrc;
  wire [2:0] msk;
  integer n_mismatch, n_compared, i;
  // addr, {kind, single-chip, ram enable}
  localparam [259:0] ATAB = {20'h8_0003, 20'hF_67F7, 20'h8_0023, 20'h7_FFF3, 20'hF_6806, 20'hF_E7F6, 20'hF_680B,
    20'h8_0009, 20'hF_6804, 20'hF_E801, 20'hF_FFF3, 20'h0_1019, 20'h0_1009};
  // {flags, number, kind}
  localparam [127:0] TTAB = {16'h1004, 16'h10F4, 16'h1004, 16'h0C05, 16'h0800, 16'h0303, 16'h0200, 16'h2002};
  cexs_seq cexs_seq_inst (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rrs), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy),
    .nmi_i(nmi), .ext_req_n_i(ereq_n), .int_req_i(ireq), .acc_valid_i(accv), .acc_addr_i(aad), .acc_kind_i(akd),
    .insn_done_i(idone), .insn_ctrl_op_i(ctl), .insn_invalid_i(inv), .insn_vtrap_i(vt), .insn_vtrap_num_i(vtn),
    .insn_ovtrap_i(ovt), .ovf_flag_i(ovf), .insn_divu_i(dvu), .divisor_zero_i(dz), .boundary_i(bnd),
    .exc_done_i(edone), .sr_load_i(srl_p), .sr_trace_i(srt), .sr_mask_i(srm), .exc_start_o(est), .exc_kind_o(ekd),
    .exc_vec_o(evc), .push_trace_o(ptr), .trace_bit_o(trb), .mask_level_o(msk), .cpu_halt_o(halt),
    .xfer_start_o(xst), .xfer_src_o(xsrc), .xfer_done_i(xdn));
  cexs_xfer_model cexs_xfer_model_inst (.clk_i(clk_i), .resetn_i(resetn_i), .xfer_start_i(xst), .slow_i(slow),
    .xfer_done_o(xdn));
  ////////////////////////////////////////////////////////////////////////////////
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  // reference decode of faulting accesses
  function aerr(input [19:0] v);
    aerr = (v[3:2] == `CEXS_ACC_WORD && v[4]) || (v[3:2] == `CEXS_ACC_FETCH && v[19:4] >= `CEXS_REGF_LO)
      || (v[1] && v[19:4] >= `CEXS_HOLE_LO && v[19:4] <= `CEXS_HOLE_HI)
      || (v[1] && !v[0] && v[19:4] >= `CEXS_RAM_LO && v[19:4] <= `CEXS_RAM_HI);
  endfunction
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_compared = n_compared + 1;
      if (g !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask
  task close_out;
    begin
      if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles: hold each channel until its own handshake edge
  task axw(input [7:0] a, input [31:0] d, output [1:0] s);
    begin
      @(posedge clk_i);
      awa <= a;
      wd <= d;
      {awv, wv, brdy} <= 3'h7;
      @(posedge clk_i);
      // no cycle limit here: only the watchdog ends a hung write
      while (bv !== 1'b1) begin
        if (awr) awv <= 1'b0;
        if (wr) wv <= 1'b0;
        @(posedge clk_i);
      end
      s = brs;
      brdy <= 1'b0;
    end
  endtask
  task axr(input [7:0] a, output [31:0] d, output [1:0] s);
    begin
      @(posedge clk_i);
      ara <= a;
      {arv, rrdy} <= 2'h3;
      @(posedge clk_i);
      while (rv !== 1'b1) begin
        if (arr) arv <= 1'b0;
        @(posedge clk_i);
      end
      d = rdt;
      s = rrs;
      rrdy <= 1'b0;
    end
  endtask
  // core-side pulses
  task insn(input [6:0] f, input [3:0] n);
    begin
      @(posedge clk_i);
      {ctl, inv, vt, ovt, ovf, dvu, dz} <= f;
      vtn <= n;
      idone <= 1'b1;
      @(posedge clk_i);
      idone <= 1'b0;
    end
  endtask
  task acc(input [15:0] a, input [1:0] k);
    begin
      @(posedge clk_i);
      aad <= a;
      akd <= k;
      accv <= 1'b1;
      @(posedge clk_i);
      accv <= 1'b0;
    end
  endtask
  task srl(input tr, input [2:0] m);
    begin
      @(posedge clk_i);
      srt <= tr;
      srm <= m;
      srl_p <= 1'b1;
      @(posedge clk_i);
      srl_p <= 1'b0;
    end
  endtask
  // offer a boundary; expect one start of the given kind, or none
  task svc(input [3:0] ek, input [4:0] ev);
    integer k;
    reg hit;
    begin
      hit = 1'b0;
      @(posedge clk_i);
      bnd <= 1'b1;
      for (k = 0; k < 12 && !hit; k = k + 1) begin
        @(posedge clk_i);
        if (est === 1'b1) begin
          hit = 1'b1;
          chk(ekd, ek);
          if (ek == `CEXS_K_VTRAP || ek == `CEXS_K_IRQ) chk(evc, ev);
        end
      end
      bnd <= 1'b0;
      if (!hit) chk(`CEXS_K_NONE, ek);
      @(posedge clk_i);
      edone <= hit;
      @(posedge clk_i);
      edone <= 1'b0;
    end
  endtask
  // route request 6 to the transfer unit; nonmaskable edge arrives during a long run, after a short one ends
  task xfr(input s);
    integer k;
    begin
      @(posedge clk_i);
      slow <= s;
      ireq[0] <= 1'b1;
      nmi <= 1'b1;
      bnd <= 1'b1;
      for (k = 0; k < 40 && halt !== 1'b1; k = k + 1) @(posedge clk_i);
      chk(xsrc, 5'h06);
      chk(halt, 1'b1);
      ireq[0] <= 1'b0;
      nmi <= 1'b0;
      for (k = 0; k < 40 && halt === 1'b1; k = k + 1) @(posedge clk_i);
      bnd <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  initial begin
    {awv, wv, brdy, arv, rrdy, accv, idone, bnd, edone, srl_p, srt, slow, ctl, inv, vt, ovt, ovf, dvu, dz} = 0;
    {awa, ara, wd, ireq, aad, akd, vtn, srm, resetn_i, n_mismatch, n_compared} = 0;
    ereq_n = 6'h3F;
    nmi = 1'b1;
    seed = 32'hb332_afcd;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    axr(`CEXS_R_CTRL, rd, r);
    chk(rd, `CEXS_CTRL_RST);
    axr(8'h18, rd, r);
    chk(rd, 32'h0000_0000);
    chk(r, `CEXS_RESP_ERR);
    axw(8'h18, 32'h0000_0001, r);
    chk(r, `CEXS_RESP_ERR);
    // pending fault and nonmaskable edge wait for the first instruction
    nmi <= 1'b0;
    acc(16'h0101, `CEXS_ACC_WORD);
    svc(`CEXS_K_NONE, 5'h00);
    insn(7'h00, 4'h0);
    svc(`CEXS_K_ADDR, 5'h00);
    svc(`CEXS_K_NMI, 5'h00);
    chk(msk, `CEXS_NMI_MASK);
    for (i = 0; i < 13; i = i + 1) begin
      e = ATAB[(12 - i) * 20 +: 20];
      axw(`CEXS_R_CTRL, {31'h0, e[1]}, r);
      axw(`CEXS_R_RAMCTL, {31'h0, e[0]}, r);
      acc(e[19:4], e[3:2]);
      insn(7'h00, 4'h0);
      svc(aerr(e) ? `CEXS_K_ADDR : `CEXS_K_NONE, 5'h00);
    end
    srl(1'b0, 3'h2);
    for (i = 0; i < 8; i = i + 1) begin
      t = TTAB[(7 - i) * 16 +: 16];
      seed = xs(seed);
      if (i == 2) t[7:4] = seed[3:0];
      insn(t[14:8], t[7:4]);
      svc(t[3:0], {1'b0, t[7:4]});
      if (t[3:0] != 4'h0) chk({trb, msk}, 4'h2);
    end
    // trace entry, fault after return, and two pending at one boundary
    srl(1'b1, 3'h2);
    insn(7'h00, 4'h0);
    svc(`CEXS_K_TRACE, 5'h00);
    chk(ptr, 1'b1);
    chk({trb, msk}, 4'h2);
    srl(1'b1, 3'h2);
    acc(16'h0101, `CEXS_ACC_WORD);
    insn(7'h00, 4'h0);
    svc(`CEXS_K_ADDR, 5'h00);
    chk({trb, msk}, 4'h2);
    svc(`CEXS_K_NONE, 5'h00);
    srl(1'b1, 3'h2);
    insn(7'h10, 4'h5);
    svc(`CEXS_K_VTRAP, 5'h05);
    svc(`CEXS_K_TRACE, 5'h00);
    chk(ptr, 1'b1);
    // request 0 at level 5 beats module 0 at level 3
    axw(`CEXS_R_PRIO0, 32'h0003_0005, r);
    srl(1'b0, 3'h0);
    ereq_n[0] <= 1'b0;
    repeat (6) @(posedge clk_i);
    ireq[0] <= 1'b1;
    svc(`CEXS_K_IRQ, 5'h00);
    ereq_n[0] <= 1'b1;
    chk(msk, 3'h5);
    svc(`CEXS_K_NONE, 5'h00);
    srl(1'b0, 3'h3);
    svc(`CEXS_K_NONE, 5'h00);
    srl(1'b0, 3'h0);
    insn(7'h40, 4'h0);
    svc(`CEXS_K_NONE, 5'h00);
    insn(7'h40, 4'h0);
    svc(`CEXS_K_NONE, 5'h00);
    insn(7'h00, 4'h0);
    svc(`CEXS_K_IRQ, 5'h06);
    ireq[0] <= 1'b0;
    chk(msk, 3'h3);
    axw(`CEXS_R_XFEREN, 32'h0000_0040, r);
    for (i = 0; i < 2; i = i + 1) begin
      srl(1'b0, 3'h0);
      xfr(i[0]);
      svc(`CEXS_K_NONE, 5'h00);
      insn(7'h00, 4'h0);
      svc(`CEXS_K_NMI, 5'h00);
      chk(msk, `CEXS_NMI_MASK);
    end
    close_out;
  end
endmodule // cpu_exception_sequencer_tb
bind cexs_seq cexs_seq_checker cexs_seq_checker_inst (.clk_i(clk_i), .resetn_i(resetn_i), .insn_done_i(insn_done_i),
  .insn_ctrl_op_i(insn_ctrl_op_i), .boundary_i(boundary_i), .xfer_done_i(xfer_done_i), .exc_start_o(exc_start_o),
  .exc_kind_o(exc_kind_o), .trace_bit_o(trace_bit_o), .mask_level_o(mask_level_o), .cpu_halt_o(cpu_halt_o),
  .xfer_start_o(xfer_start_o));
